// ---- rtl/csflm_pkg.sv ----
// Purpose: shared constants for the charge state, flag and load model block
// Assumes: core_clk at 10 MHz, charge in mAh, current in mA, voltage in mV
// Notes:   one update period per second drives all integration
package csflm_pkg;
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned UPDATE_MS     = 1000;
	localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * UPDATE_MS;
	localparam int unsigned FILT_TAU_S    = 14;
	localparam int          FILT_DIV      = int'(FILT_TAU_S * 1000 / UPDATE_MS);
	localparam int          MAS_PER_MAH   = 3600;
	localparam int          DSG_THR_MA    = 10;
	localparam int          RATE_DIV      = 5;
	localparam int          DROP_SHIFT    = 10;
	localparam int          RSV_SHIFT     = 3;

	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_STAT     = 8'h04;
	localparam logic [7:0]  ADDR_THR1     = 8'h08;
	localparam logic [7:0]  ADDR_THRF     = 8'h0C;
	localparam logic [7:0]  ADDR_DSGN     = 8'h10;
	localparam logic [7:0]  ADDR_RATE     = 8'h14;
	localparam logic [7:0]  ADDR_RSV      = 8'h18;
	localparam logic [7:0]  ADDR_EFF      = 8'h1C;
	localparam logic [7:0]  ADDR_QMAX     = 8'h20;
	localparam logic [7:0]  ADDR_REM      = 8'h24;
	localparam logic [7:0]  ADDR_FULL     = 8'h28;
	localparam logic [7:0]  ADDR_LOAD     = 8'h2C;

	localparam int          CTRL_LMODE    = 0;
	localparam int          CTRL_HOLD     = 1;
	localparam int          CTRL_RSV      = 2;
	localparam int          CTRL_LSEL     = 4;

	localparam logic [31:0] CTRL_RST      = 32'h0000_0010;
	localparam logic [31:0] THR1_RST      = 32'h00AF_0096;
	localparam logic [31:0] THRF_RST      = 32'h0064_004B;
	localparam logic [31:0] DSGN_RST      = 32'h0E10_03E8;
	localparam logic [31:0] RATE_RST      = 32'h0000_0000;
	localparam logic [31:0] RSV_RST       = 32'h0040_0000;
	localparam logic [31:0] EFF_RST       = 32'h6464_6464;
	localparam logic [15:0] QMAX_RST      = 16'h03E8;
	localparam logic [7:0]  SOC_RST       = 8'h64;

	localparam logic [2:0]  LSEL_PREV     = 3'h0;
	localparam logic [2:0]  LSEL_PRES     = 3'h1;
	localparam logic [2:0]  LSEL_AVG      = 3'h2;
	localparam logic [2:0]  LSEL_FILT     = 3'h3;
	localparam logic [2:0]  LSEL_DESIGN   = 3'h4;
	localparam logic [2:0]  LSEL_USER     = 3'h6;

	typedef enum logic [2:0] {
		DIR_REST = 3'b001,
		DIR_CHG  = 3'b010,
		DIR_DSG  = 3'b100
	} csflm_dir_e;

	typedef enum logic [1:0] {
		AP_IDLE = 2'b01,
		AP_ACK  = 2'b10
	} csflm_apb_e;
endpackage

// ---- rtl/csflm_flag.sv ----
// Purpose: one low-charge warning flag with set and clear thresholds
// Assumes: thresholds signed mAh, level unsigned mAh
// Notes:   set wins if both thresholds trip in one evaluation
`timescale 1ns/1ns
module csflm_flag #(
	parameter bit HAS_DISABLE = 1'b0
) (
	input  wire logic               core_clk,
	input  wire logic               rstn,
	input  wire logic               eval,
	input  wire logic        [15:0] level,
	input  wire logic signed [15:0] set_thr,
	input  wire logic signed [15:0] clr_thr,
	output logic                    flag
);
	logic        flag_ff;
	logic signed [16:0] lvl_s;
	logic        set_hit;
	logic        clr_hit;

	assign lvl_s   = $signed({1'b0, level});
	// all-ones set threshold keeps the flag from setting where supported; a set flag still clears above the clear threshold
	assign set_hit = (lvl_s < set_thr) && !(HAS_DISABLE && set_thr == -16'sd1);
	assign clr_hit = flag_ff && (lvl_s > clr_thr);
	assign flag    = flag_ff;

	always_ff @(posedge core_clk) begin
		if (!rstn)
			flag_ff <= 1'b0;
		else if (eval && set_hit)
			flag_ff <= 1'b1;
		else if (eval && clr_hit)
			flag_ff <= 1'b0;
	end

	a_flag_set_low: assert property (@(posedge core_clk) disable iff (!rstn)
		eval && set_hit |=> flag_ff) else $error("flag not set below threshold");
	a_flag_clear_high: assert property (@(posedge core_clk) disable iff (!rstn)
		eval && !set_hit && flag_ff && lvl_s > clr_thr |=> !flag_ff)
		else $error("flag not cleared above threshold");
	a_flag_hyst_hold: assert property (@(posedge core_clk) disable iff (!rstn)
		eval && !set_hit && lvl_s <= clr_thr |=> flag_ff == $past(flag_ff))
		else $error("flag moved inside hysteresis band");
	a_flag_disabled: assert property (@(posedge core_clk) disable iff (!rstn)
		HAS_DISABLE && set_thr == -16'sd1 && !flag_ff |=> !flag_ff)
		else $error("disabled flag was set");
endmodule // csflm_flag

// ---- rtl/csflm_top.sv ----
// Purpose: charge integration, capacity reporting, low-charge flags, load model
// Assumes: samples synchronous to core_clk; current mA (+ is charge), voltage mV
// Notes:   APB slave, one wait state on every access
`timescale 1ns/1ns
module csflm_top #(
	parameter int unsigned TICK_CYCLES = csflm_pkg::TICK_CYC
) (
	input  wire logic               core_clk,
	input  wire logic               rstn,
	input  wire logic        [7:0]  paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic        [31:0] pwdata,
	output logic             [31:0] prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic signed [15:0] sample_current,
	input  wire logic        [15:0] sample_voltage,
	input  wire logic signed [15:0] running_avg_current,
	output logic                    initial_low_charge_flag,
	output logic                    final_low_charge_flag,
	output logic                    load_model_type_status,
	output logic             [15:0] remaining_charge_value,
	output logic             [15:0] compensated_full_value,
	output logic             [15:0] uncomp_remaining_value,
	output logic             [15:0] uncomp_full_value,
	output logic             [7:0]  charge_percent,
	output logic                    update_tick
);
	csflm_pkg::csflm_apb_e ap_ff;
	csflm_pkg::csflm_dir_e dir_ff;
	csflm_pkg::csflm_dir_e nxt_dir;
	logic        [31:0] prdata_ff, rd_data, ctrl_ff, thr1_ff, thrf_ff;
	logic        [31:0] dsgn_ff, rate_ff, rsv_ff, eff_ff;
	logic        [15:0] qmax_ff;
	logic               pready_ff, pslverr_ff, hit, ro_addr, wr_en;
	logic        [23:0] tick_cnt_ff;
	logic               tick_ff, upd_ff, flag_upd_ff;
	logic signed [23:0] acc_ff;
	logic        [15:0] nom_ff, rem_ff, full_ff, load_ff, last_i_ff, last_p_ff;
	logic        [7:0]  soc_ff;
	logic        [31:0] isum_ff, psum_ff;
	logic        [15:0] n_ff;
	logic               first_ff;
	logic signed [15:0] filt_ff;
	int                 cur_eff, nxt_acc, nxt_nom, mag, pwr_inst, acc_mah;
	int                 pres_i, pres_p, avg_mag, filt_mag, load_raw, load_ma;
	int                 drop, nxt_full, rsv_eff, nxt_rem, nxt_soc;
	logic        [7:0]  eff_q;
	logic        [2:0]  lsel;
	logic               lmode;

	assign lmode = ctrl_ff[csflm_pkg::CTRL_LMODE];
	assign lsel  = ctrl_ff[csflm_pkg::CTRL_LSEL +: 3];

	// register bus: read data latched in the wait cycle, write lands on the ready edge
	always_comb begin
		hit     = 1'b1;
		ro_addr = 1'b0;
		rd_data = 32'h0000_0000;
		case (paddr)
			csflm_pkg::ADDR_CTRL: rd_data = ctrl_ff;
			csflm_pkg::ADDR_STAT: begin
				ro_addr = 1'b1;
				rd_data = {27'h000_0000, first_ff, dir_ff == csflm_pkg::DIR_DSG,
					lmode, final_low_charge_flag, initial_low_charge_flag};
			end
			csflm_pkg::ADDR_THR1: rd_data = thr1_ff;
			csflm_pkg::ADDR_THRF: rd_data = thrf_ff;
			csflm_pkg::ADDR_DSGN: rd_data = dsgn_ff;
			csflm_pkg::ADDR_RATE: rd_data = rate_ff;
			csflm_pkg::ADDR_RSV:  rd_data = rsv_ff;
			csflm_pkg::ADDR_EFF:  rd_data = eff_ff;
			csflm_pkg::ADDR_QMAX: rd_data = {16'h0000, qmax_ff};
			csflm_pkg::ADDR_REM: begin
				ro_addr = 1'b1;
				rd_data = {nom_ff, rem_ff};
			end
			csflm_pkg::ADDR_FULL: begin
				ro_addr = 1'b1;
				rd_data = {qmax_ff, full_ff};
			end
			csflm_pkg::ADDR_LOAD: begin
				ro_addr = 1'b1;
				rd_data = {8'h00, soc_ff, load_ff};
			end
			default: hit = 1'b0;
		endcase
	end

	assign wr_en = ap_ff == csflm_pkg::AP_ACK && psel && pwrite && hit && !ro_addr;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			ap_ff      <= csflm_pkg::AP_IDLE;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			case (ap_ff)
				csflm_pkg::AP_IDLE: begin
					if (psel && penable) begin
						ap_ff      <= csflm_pkg::AP_ACK;
						pready_ff  <= 1'b1;
						pslverr_ff <= !hit || (pwrite && ro_addr);
						prdata_ff  <= pwrite ? 32'h0000_0000 : rd_data;
					end
				end
				csflm_pkg::AP_ACK: begin
					ap_ff      <= csflm_pkg::AP_IDLE;
					pready_ff  <= 1'b0;
					pslverr_ff <= 1'b0;
				end
				default: ap_ff <= csflm_pkg::AP_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			ctrl_ff <= csflm_pkg::CTRL_RST;
			thr1_ff <= csflm_pkg::THR1_RST;
			thrf_ff <= csflm_pkg::THRF_RST;
			dsgn_ff <= csflm_pkg::DSGN_RST;
			rate_ff <= csflm_pkg::RATE_RST;
			rsv_ff  <= csflm_pkg::RSV_RST;
			eff_ff  <= csflm_pkg::EFF_RST;
			qmax_ff <= csflm_pkg::QMAX_RST;
		end else if (wr_en) begin
			case (paddr)
				csflm_pkg::ADDR_CTRL: ctrl_ff <= pwdata & 32'h0000_0077;
				csflm_pkg::ADDR_THR1: thr1_ff <= pwdata;
				csflm_pkg::ADDR_THRF: thrf_ff <= pwdata;
				csflm_pkg::ADDR_DSGN: dsgn_ff <= pwdata;
				csflm_pkg::ADDR_RATE: rate_ff <= pwdata;
				csflm_pkg::ADDR_RSV:  rsv_ff  <= pwdata;
				csflm_pkg::ADDR_EFF:  eff_ff  <= pwdata;
				csflm_pkg::ADDR_QMAX: qmax_ff <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// update period divider
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			tick_cnt_ff <= 24'h00_0000;
			tick_ff     <= 1'b0;
		end else begin
			tick_ff     <= tick_cnt_ff == 24'(TICK_CYCLES - 1);
			tick_cnt_ff <= (tick_cnt_ff == 24'(TICK_CYCLES - 1)) ? 24'h00_0000
				: tick_cnt_ff + 24'h00_0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			upd_ff      <= 1'b0;
			flag_upd_ff <= 1'b0;
		end else begin
			upd_ff      <= tick_ff;
			flag_upd_ff <= upd_ff;
		end
	end

	// direction, efficiency and charge integration
	always_comb begin
		if (int'(sample_current) < -csflm_pkg::DSG_THR_MA)
			nxt_dir = csflm_pkg::DIR_DSG;
		else if (int'(sample_current) > csflm_pkg::DSG_THR_MA)
			nxt_dir = csflm_pkg::DIR_CHG;
		else
			nxt_dir = csflm_pkg::DIR_REST;
		if (soc_ff < 8'h19)
			eff_q = eff_ff[7:0];
		else if (soc_ff < 8'h32)
			eff_q = eff_ff[15:8];
		else if (soc_ff < 8'h4B)
			eff_q = eff_ff[23:16];
		else
			eff_q = eff_ff[31:24];
		cur_eff = int'(sample_current);
		if (cur_eff > 0)
			cur_eff = cur_eff * int'(eff_q) / 100;
		nxt_acc = int'(acc_ff) + cur_eff;
		// whole mAh move at once, so fast currents never pile up in the remainder
		acc_mah = nxt_acc / csflm_pkg::MAS_PER_MAH;
		nxt_acc = nxt_acc - acc_mah * csflm_pkg::MAS_PER_MAH;
		nxt_nom = int'(nom_ff) + acc_mah;
		if (nxt_nom > int'(qmax_ff))
			nxt_nom = int'(qmax_ff);
		if (nxt_nom < 0)
			nxt_nom = 0;
		mag      = (cur_eff < 0) ? -cur_eff : 0;
		pwr_inst = mag * int'(sample_voltage) / 1000;
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			acc_ff <= 24'sh00_0000;
			nom_ff <= csflm_pkg::QMAX_RST;
			dir_ff <= csflm_pkg::DIR_REST;
		end else if (tick_ff) begin
			acc_ff <= 24'(nxt_acc);
			nom_ff <= 16'(nxt_nom);
			dir_ff <= nxt_dir;
		end
	end

	// discharge run statistics; a run ends when direction leaves discharge
	assign pres_i = (n_ff != 16'h0000) ? int'(isum_ff / {16'h0000, n_ff}) : 0;
	assign pres_p = (n_ff != 16'h0000) ? int'(psum_ff / {16'h0000, n_ff}) : 0;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			isum_ff   <= 32'h0000_0000;
			psum_ff   <= 32'h0000_0000;
			n_ff      <= 16'h0000;
			last_i_ff <= 16'h0000;
			last_p_ff <= 16'h0000;
			first_ff  <= 1'b1;
		end else if (tick_ff) begin
			if (nxt_dir == csflm_pkg::DIR_DSG && n_ff != 16'hFFFF) begin
				isum_ff <= isum_ff + 32'(mag);
				psum_ff <= psum_ff + 32'(pwr_inst);
				n_ff    <= n_ff + 16'h0001;
			end else if (nxt_dir != csflm_pkg::DIR_DSG && n_ff != 16'h0000) begin
				last_i_ff <= 16'(pres_i);
				last_p_ff <= 16'(pres_p);
				first_ff  <= 1'b0;
				isum_ff   <= 32'h0000_0000;
				psum_ff   <= 32'h0000_0000;
				n_ff      <= 16'h0000;
			end
		end
	end

	// first-order low pass on the running average
	always_ff @(posedge core_clk) begin
		if (!rstn)
			filt_ff <= 16'sh0000;
		else if (tick_ff)
			filt_ff <= 16'(int'(filt_ff) + (int'(running_avg_current) - int'(filt_ff))
				/ csflm_pkg::FILT_DIV);
	end

	// load model selection and capacity compensation
	always_comb begin
		avg_mag  = (running_avg_current < 0) ? -int'(running_avg_current)
			: int'(running_avg_current);
		filt_mag = (filt_ff < 0) ? -int'(filt_ff) : int'(filt_ff);
		if (!lmode) begin
			case (lsel)
				csflm_pkg::LSEL_PREV:   load_raw = first_ff ? pres_i : int'(last_i_ff);
				csflm_pkg::LSEL_PRES:   load_raw = pres_i;
				csflm_pkg::LSEL_AVG:    load_raw = avg_mag;
				csflm_pkg::LSEL_FILT:   load_raw = filt_mag;
				csflm_pkg::LSEL_DESIGN: load_raw = int'(dsgn_ff[15:0]) / csflm_pkg::RATE_DIV;
				csflm_pkg::LSEL_USER:   load_raw = int'(rate_ff[15:0]);
				default:                load_raw = pres_i;
			endcase
			load_ma = load_raw;
		end else begin
			case (lsel)
				csflm_pkg::LSEL_PREV:   load_raw = int'(last_p_ff);
				csflm_pkg::LSEL_PRES:   load_raw = pres_p;
				csflm_pkg::LSEL_AVG:    load_raw = avg_mag * int'(sample_voltage) / 1000;
				csflm_pkg::LSEL_FILT:   load_raw = filt_mag * int'(sample_voltage) / 1000;
				csflm_pkg::LSEL_DESIGN: load_raw = int'(dsgn_ff[31:16]) / csflm_pkg::RATE_DIV;
				csflm_pkg::LSEL_USER:   load_raw = int'(rate_ff[31:16]);
				default:                load_raw = int'(last_p_ff);
			endcase
			// power model turns into an equivalent current at the present voltage
			load_ma = (sample_voltage != 16'h0000)
				? load_raw * 1000 / int'(sample_voltage) : 0;
		end
		if (load_ma > 32'sd65535)
			load_ma = 32'sd65535;
		drop     = (load_ma * int'(rsv_ff[31:16])) >>> csflm_pkg::DROP_SHIFT;
		nxt_full = int'(qmax_ff) - drop;
		if (nxt_full < 0)
			nxt_full = 0;
		rsv_eff  = int'(rsv_ff[15:0]);
		if (ctrl_ff[csflm_pkg::CTRL_RSV])
			rsv_eff = rsv_eff + (drop >>> csflm_pkg::RSV_SHIFT);
		nxt_rem  = int'(nom_ff) - drop - rsv_eff;
		if (nxt_rem < 0)
			nxt_rem = 0;
		if (nxt_rem > nxt_full)
			nxt_rem = nxt_full;
		nxt_soc  = (nxt_full != 0) ? nxt_rem * 100 / nxt_full : 0;
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rem_ff  <= 16'h0000;
			full_ff <= csflm_pkg::QMAX_RST;
			load_ff <= 16'h0000;
			soc_ff  <= csflm_pkg::SOC_RST;
		end else if (upd_ff) begin
			rem_ff  <= 16'(nxt_rem);
			full_ff <= 16'(nxt_full);
			load_ff <= 16'(load_raw);
			// hold only blocks a rise; a falling value is always taken
			if (!(ctrl_ff[csflm_pkg::CTRL_HOLD] && dir_ff == csflm_pkg::DIR_DSG
				&& 8'(nxt_soc) > soc_ff))
				soc_ff <= 8'(nxt_soc);
		end
	end

	// flags look at the freshly updated remaining charge
	csflm_flag #(.HAS_DISABLE(1'b0)) u_flag_init (.core_clk(core_clk), .rstn(rstn),
		.eval(flag_upd_ff), .level(rem_ff), .set_thr(thr1_ff[15:0]),
		.clr_thr(thr1_ff[31:16]), .flag(initial_low_charge_flag));
	csflm_flag #(.HAS_DISABLE(1'b1)) u_flag_final (.core_clk(core_clk), .rstn(rstn),
		.eval(flag_upd_ff), .level(rem_ff), .set_thr(thrf_ff[15:0]),
		.clr_thr(thrf_ff[31:16]), .flag(final_low_charge_flag));

	assign prdata                 = prdata_ff;
	assign pready                 = pready_ff;
	assign pslverr                = pslverr_ff;
	assign load_model_type_status = ctrl_ff[csflm_pkg::CTRL_LMODE];
	assign remaining_charge_value = rem_ff;
	assign compensated_full_value = full_ff;
	assign uncomp_remaining_value = nom_ff;
	assign uncomp_full_value      = qmax_ff;
	assign charge_percent         = soc_ff;
	assign update_tick            = upd_ff;

	a_apb_wait_one: assert property (@(posedge core_clk) disable iff (!rstn)
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer not after one wait cycle");
	a_lmode_mirror: assert property (@(posedge core_clk) disable iff (!rstn)
		wr_en && paddr == csflm_pkg::ADDR_CTRL |=> load_model_type_status == $past(pwdata[0]))
		else $error("load mode status not mirrored");
	a_soc_no_rise: assert property (@(posedge core_clk) disable iff (!rstn)
		upd_ff && ctrl_ff[csflm_pkg::CTRL_HOLD] && dir_ff == csflm_pkg::DIR_DSG
		|=> charge_percent <= $past(charge_percent)) else $error("charge rose during hold");
	a_dsg_no_gain: assert property (@(posedge core_clk) disable iff (!rstn)
		tick_ff && sample_current < 0 |=> uncomp_remaining_value <= $past(uncomp_remaining_value))
		else $error("discharge raised charge");
	a_design_rate: assert property (@(posedge core_clk) disable iff (!rstn)
		upd_ff && !lmode && lsel == csflm_pkg::LSEL_DESIGN
		|=> load_ff == $past(dsgn_ff[15:0]) / 16'd5) else $error("design rate load wrong");
	a_reserve_held: assert property (@(posedge core_clk) disable iff (!rstn)
		upd_ff |=> 17'(remaining_charge_value) + 17'($past(rsv_ff[15:0]))
		<= 17'($past(nom_ff)) || remaining_charge_value == 16'h0000)
		else $error("reserve not held back");
	a_flag_follows: assert property (@(posedge core_clk) disable iff (!rstn)
		$changed(initial_low_charge_flag) || $changed(final_low_charge_flag)
		|-> $past(flag_upd_ff)) else $error("flag moved outside update");
endmodule // csflm_top

// ---- dv/csflm_cell_model.sv ----
// Purpose: cell and sense front end feeding the gauge samples
// Assumes: commanded current in mA, + is charge
// Notes:   fixed pack voltage; average follows the command at once
`timescale 1ns/1ns
module csflm_cell_model (
	input  wire logic               core_clk,
	input  wire logic               rstn,
	input  wire logic signed [15:0] cmd_ma,
	output logic signed      [15:0] sample_current,
	output logic             [15:0] sample_voltage,
	output logic signed      [15:0] running_avg_current
);
	// registered so a change never lands inside the sampling edge
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sample_current      <= 16'sh0000;
			running_avg_current <= 16'sh0000;
			sample_voltage      <= 16'h0E74;
		end else begin
			sample_current      <= cmd_ma;
			running_avg_current <= cmd_ma;
			sample_voltage      <= 16'h0E74;
		end
	end
endmodule // csflm_cell_model

// ---- dv/tb_charge_state_flags_load_model.sv ----
// Purpose: self-checking bench for charge, flags and load model
// Assumes: short update period, load coefficient zeroed
// Notes:   flags modelled with hysteresis in the bench
`timescale 1ns/1ns
module tb_charge_state_flags_load_model;
	localparam int      TICKS = 20;
	logic               core_clk = 1'b0;
	logic               rstn = 1'b0;
	logic        [7:0]  paddr = 8'h00;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic        [31:0] pwdata = 32'h0000_0000;
	logic        [31:0] prdata;
	logic               pready;
	logic               pslverr;
	logic signed [15:0] cmd_ma = 16'sh0000;
	logic signed [15:0] s_cur;
	logic signed [15:0] s_avg;
	logic        [15:0] s_volt;
	logic               ilf;
	logic               flf;
	logic               lmode;
	logic               tick;
	logic        [15:0] rem;
	logic        [15:0] cfull;
	logic        [15:0] urem;
	logic        [15:0] ufull;
	logic        [7:0]  pct;
	logic        [31:0] rd;
	logic               er;
	logic               exp_i = 1'b0;
	logic               exp_f = 1'b0;
	int                 exp_rem = 1000;
	int                 sf = -1;
	int                 exp_rsv = 0;
	logic               keep_cmd = 1'b0;
	int                 n_mismatch = 0;
	int                 n_checks = 0;

	always #50 core_clk = ~core_clk;

	csflm_cell_model i_cell (.core_clk(core_clk), .rstn(rstn), .cmd_ma(cmd_ma),
		.sample_current(s_cur), .sample_voltage(s_volt), .running_avg_current(s_avg));

	csflm_top #(.TICK_CYCLES(TICKS)) i_dut (.core_clk(core_clk), .rstn(rstn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_current(s_cur),
		.sample_voltage(s_volt), .running_avg_current(s_avg),
		.initial_low_charge_flag(ilf), .final_low_charge_flag(flf),
		.load_model_type_status(lmode), .remaining_charge_value(rem),
		.compensated_full_value(cfull), .uncomp_remaining_value(urem),
		.uncomp_full_value(ufull), .charge_percent(pct), .update_tick(tick));

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// no cycle count assumed; a stuck slave is cut by the watchdog
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// sync to an update first so the new current covers whole periods
	task automatic step(input int ma, input int n);
		int lvl;
		do @(posedge core_clk); while (tick !== 1'b1);
		cmd_ma <= 16'(ma);
		repeat (n) begin
			do @(posedge core_clk); while (tick !== 1'b1);
			repeat (2) @(posedge core_clk);
			#1;
			exp_rem += ma / 3600;
			lvl = exp_rem - exp_rsv;
			if (lvl < 980) exp_i = 1'b1;
			else if (lvl > 990) exp_i = 1'b0;
			if (sf != -1 && lvl < sf) exp_f = 1'b1;
			else if (exp_f && lvl > 990) exp_f = 1'b0;
			chk(32'(urem), 32'(exp_rem));
			chk(32'(rem), 32'(lvl));
			chk({cfull, ufull}, {16'h03E8, 16'h03E8});
			chk({30'h0, ilf, flf}, {30'h0, exp_i, exp_f});
		end
		// rest afterwards, else the next sync period runs on an uncounted current
		if (!keep_cmd) begin
			@(posedge core_clk);
			cmd_ma <= 16'sh0000;
		end
	endtask

	task automatic regs_reset;
		chk({8'h00, pct, ufull}, {8'h00, 8'h64, 16'h03E8});
		apb(1'b0, csflm_pkg::ADDR_CTRL, 32'h0);
		chk(rd, csflm_pkg::CTRL_RST);
		apb(1'b0, csflm_pkg::ADDR_THR1, 32'h0);
		chk(rd, csflm_pkg::THR1_RST);
		apb(1'b1, csflm_pkg::ADDR_STAT, 32'hFFFF_FFFF);
		chk({31'h0, er}, 32'h0000_0001);
		apb(1'b0, 8'h30, 32'h0);
		chk({rd[30:0], er}, 32'h0000_0001);
	endtask

	task automatic load_sel(input logic [31:0] ctrl, input int ma, input logic [15:0] exp);
		apb(1'b1, csflm_pkg::ADDR_CTRL, ctrl);
		step(ma, 1);
		apb(1'b0, csflm_pkg::ADDR_LOAD, 32'h0);
		chk({16'h0, rd[15:0]}, {16'h0, exp});
		apb(1'b0, csflm_pkg::ADDR_STAT, 32'h0);
		chk({30'h0, lmode, rd[2]}, {30'h0, ctrl[0], ctrl[0]});
	endtask

	// dropping the reserve mid-discharge would lift the percent; hold must block it
	task automatic hold_rise;
		apb(1'b1, csflm_pkg::ADDR_CTRL, 32'h0000_0012);
		apb(1'b1, csflm_pkg::ADDR_RSV, 32'h0000_0064);
		exp_rsv = 100;
		keep_cmd = 1'b1;
		step(-3600, 1);
		chk({24'h0, pct}, 32'h0000_0059);
		apb(1'b1, csflm_pkg::ADDR_RSV, 32'h0000_0000);
		exp_rsv = 0;
		keep_cmd = 1'b0;
		// the discharge keeps running through the write for one more period
		exp_rem += -3600 / 3600;
		step(-3600, 1);
		chk({24'h0, pct}, 32'h0000_0059);
	endtask

	initial begin
		repeat (10) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		#1;
		regs_reset();
		apb(1'b1, csflm_pkg::ADDR_RSV, 32'h0000_0000);
		apb(1'b1, csflm_pkg::ADDR_THR1, 32'h03DE_03D4);
		apb(1'b1, csflm_pkg::ADDR_THRF, 32'h03DE_FFFF);
		apb(1'b1, csflm_pkg::ADDR_RATE, 32'h0258_0123);
		step(0, 2);
		step(-18000, 6);
		apb(1'b1, csflm_pkg::ADDR_THRF, 32'h03DE_03CA);
		sf = 970;
		step(-18000, 2);
		step(18000, 8);
		load_sel(32'h0000_0040, 0, 16'h00C8);
		load_sel(32'h0000_0060, 0, 16'h0123);
		load_sel(32'h0000_0041, 0, 16'h02D0);
		load_sel(32'h0000_0061, 0, 16'h0258);
		load_sel(32'h0000_0020, -3600, 16'h0E10);
		load_sel(32'h0000_0010, -3600, 16'h0E10);
		load_sel(32'h0000_0021, -3600, 16'h3408);
		hold_rise();
		wrap_up();
	end

	initial begin
		#(6000 * 100);
		n_mismatch++;
		wrap_up();
	end
endmodule // tb_charge_state_flags_load_model
